/* rtl/csf_consts.vh */
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
`define CSF_NBRD        5
`define CSF_NLINK       10
`define CSF_NLAY        6
`define CSF_BRD_LINES   48
`define CSF_LAY_LINES   8
`define CSF_LINK_LAYS   3
`define CSF_NDS         240
`define CSF_NHS         960
`define CSF_HSW         160
`define CSF_DSW         40
`define CSF_BRD_HS      32
`define CSF_BRD_DS      8
`define CSF_HS_PER_DS   4
`define CSF_KEY_LAY     2
`define CSF_NPAT        3
`define CSF_GRP_HS      32
`define CSF_GRP_DS      8
`define CSF_NGRP        5
`define CSF_NCAND       10
`define CSF_CLK_MHZ     25
`define CSF_STRETCH_NS  75
`define CSF_STRETCH_CYC ((`CSF_STRETCH_NS * `CSF_CLK_MHZ + 999) / 1000)
`define CSF_DELAY_NS    50
`define CSF_DELAY_CYC   ((`CSF_DELAY_NS * `CSF_CLK_MHZ + 999) / 1000)
`define CSF_PRETRIG_N   2
`define CSF_PATTERN_M   4
`define CSF_PIPE_DEPTH  4
`define CSF_FIFO_DEPTH  16
`define CSF_FIFO_AW     4
`define CSF_WORD_W      24
`define CSF_RD_LAST     8'hef
`define CSF_ONE4        4'h1
`endif

/* rtl/csf_fifo.v */
`timescale 1ns/1ps
`default_nettype none

// DEPTH must be a power of two; the pointers wrap naturally.
module csf_fifo #(
	parameter WIDTH  = 24,
	parameter DEPTH  = 16,
	parameter ADDR_W = 4
) (
	input  wire              clk,       // Board clock.
	input  wire              rst,       // Synchronous reset, active high.
	input  wire              in_valid,  // Write request.
	output wire              in_ready,  // Not full.
	input  wire [WIDTH-1:0]  in_data,   // Write word.
	output wire              out_valid, // Not empty.
	input  wire              out_ready, // Read acknowledge.
	output wire [WIDTH-1:0]  out_data   // Head word.
);

localparam [ADDR_W:0] FULL = DEPTH[ADDR_W:0];

reg  [WIDTH-1:0]  mem [0:DEPTH-1];
reg  [ADDR_W-1:0] wr_ptr;
reg  [ADDR_W-1:0] rd_ptr;
reg  [ADDR_W:0]   count;
wire              wr;
wire              rd;

assign in_ready  = (count != FULL);
assign out_valid = (count != {(ADDR_W+1){1'b0}});
assign out_data  = mem[rd_ptr];
assign wr        = in_valid & in_ready;
assign rd        = out_valid & out_ready;

always @(posedge clk)
begin
	if (wr)
		mem[wr_ptr] <= in_data;
	if (rst)
	begin
		wr_ptr <= {ADDR_W{1'b0}};
		rd_ptr <= {ADDR_W{1'b0}};
		count  <= {(ADDR_W+1){1'b0}};
	end
	else
	begin
		if (wr)
			wr_ptr <= wr_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
		if (rd)
			rd_ptr <= rd_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
		if (wr & ~rd)
			count <= count + {{ADDR_W{1'b0}}, 1'b1};
		else if (rd & ~wr)
			count <= count - {{ADDR_W{1'b0}}, 1'b1};
	end
end

endmodule
`default_nettype wire

/* rtl/csf_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.vh"

module csf_top (
	input  wire                    clk,                      // Board clock, 25 MHz.
	input  wire                    rst,                      // Synchronous reset, active high.
	input  wire [`CSF_NDS-1:0]     fe_data,                  // Comparator triad lines.
	input  wire [`CSF_NBRD-1:0]    fe_clk,                   // Clock returned by each board.
	input  wire [`CSF_NLINK-1:0]   fe_link_id,               // Link identifier bits.
	input  wire [`CSF_NLINK-1:0]   fe_link_alive,            // Link-alive bits.
	input  wire [`CSF_NDS-1:0]     phase_sel,                // 1 selects falling-edge copy.
	input  wire [`CSF_NDS-1:0]     chan_mask,                // 1 kills a di-strip channel.
	input  wire [3:0]              stretch_len,              // Hit stretch in cycles.
	input  wire [2:0]              pretrig_n,                // Pre-trigger layer threshold.
	input  wire [2:0]              pattern_m,                // Pattern layer threshold.
	input  wire [3:0]              pretrig_delay,            // Wait in cycles after pre-trigger.
	input  wire                    level_one_accept,         // Trigger accept level.
	input  wire [4:0]              level_one_accept_crossing, // Crossing of the accept.
	input  wire                    seg_ready,                // Coincidence board takes word.
	output reg  [`CSF_WORD_W-1:0]  seg_word,                 // Segment word to the board.
	output reg                     seg_valid,                // Word is presented.
	output reg                     pretrig,                  // Pre-trigger pulse.
	output reg  [`CSF_NLINK-1:0]   link_ok,                  // Link alive with right id.
	output reg                     diag_bit,                 // Serial diagnostic data.
	output reg                     diag_valid                // Diagnostic bit is valid.
);

localparam [2:0] ST_IDLE  = 3'h0;
localparam [2:0] ST_DELAY = 3'h1;
localparam [2:0] ST_EVAL  = 3'h2;
localparam [2:0] ST_PUSH1 = 3'h3;
localparam [2:0] ST_PUSH2 = 3'h4;

// ****************************************************************
// Helper functions
// ****************************************************************

// Window of three positions around c in layer l; outside the chamber reads as no hit.
function win3(input [`CSF_NHS-1:0] v, input integer l, input integer c, input integer w);
	integer i;
	reg     r;
	begin
		r = 1'b0;
		for (i = c - 1; i <= c + 1; i = i + 1)
			if (i >= 0 && i < w)
				r = r | v[l * w + i];
		win3 = r;
	end
endfunction

// Pattern number: kind, layer count, straight flag, zero, pattern code.
function [7:0] mkpn(input hd, input [2:0] lay, input integer s);
	reg [1:0] sc;
	begin
		sc   = s[1:0];
		mkpn = {hd, lay, (sc == 2'h0), 1'b0, sc};
	end
endfunction

function [`CSF_WORD_W-1:0] mkword(input [7:0] pn, input bend, input hd, input [7:0] pos,
	input [4:0] cr);
	begin
		mkword = {1'b1, pn, bend, hd, pos, cr};
	end
endfunction

// ****************************************************************
// Link clocks and link status
// ****************************************************************

reg  [`CSF_NBRD-1:0]  lclk_s1;
reg  [`CSF_NBRD-1:0]  lclk_s2;
reg  [`CSF_NBRD-1:0]  lclk_s3;
reg  [`CSF_NLINK-1:0] id_s1;
reg  [`CSF_NLINK-1:0] id_s2;
reg  [`CSF_NLINK-1:0] alive_s1;
reg  [`CSF_NLINK-1:0] alive_s2;
wire [`CSF_NBRD-1:0]  lclk_edge;
wire [`CSF_NLINK-1:0] id_expect;
reg  [4:0]            crossing;

genvar gj;
generate
	for (gj = 0; gj < `CSF_NLINK; gj = gj + 1)
	begin : g_id
		assign id_expect[gj] = (gj % 2 == 1);
	end
endgenerate

assign lclk_edge = lclk_s2 & ~lclk_s3;

always @(posedge clk)
begin
	lclk_s1  <= fe_clk;
	lclk_s2  <= lclk_s1;
	lclk_s3  <= lclk_s2;
	id_s1    <= fe_link_id;
	id_s2    <= id_s1;
	alive_s1 <= fe_link_alive;
	alive_s2 <= alive_s1;
	if (rst)
	begin
		link_ok  <= {`CSF_NLINK{1'b0}};
		crossing <= 5'h00;
	end
	else
	begin
		link_ok  <= alive_s2 & ~(id_s2 ^ id_expect);
		crossing <= crossing + 5'h01;
	end
end

// ****************************************************************
// Input capture, mask, triad decoding and stretching
// ****************************************************************

wire [`CSF_NDS-1:0] raw;
wire [`CSF_NHS-1:0] hs;
wire [`CSF_NDS-1:0] ds;

genvar gi;
generate
	for (gi = 0; gi < `CSF_NDS; gi = gi + 1)
	begin : g_line
		localparam integer BRD = gi / `CSF_BRD_LINES;
		localparam integer LAY = (gi % `CSF_BRD_LINES) / `CSF_LAY_LINES;
		localparam integer LN  = gi % `CSF_LAY_LINES;
		localparam integer LNK = BRD * 2 + LAY / `CSF_LINK_LAYS;
		localparam integer DSI = LAY * `CSF_DSW + BRD * `CSF_BRD_DS + LN;
		localparam integer HSI = LAY * `CSF_HSW + BRD * `CSF_BRD_HS + LN * `CSF_HS_PER_DS;
		reg       r1;
		reg       r2;
		reg       f1;
		reg       f2;
		reg       q;
		reg [1:0] step;
		reg       sb;
		reg [3:0] timer;
		reg [3:0] hv;
		wire      bit_in;

		always @(posedge clk)
		begin
			r1 <= fe_data[gi];
			r2 <= r1;
		end
		always @(negedge clk)
		begin
			f1 <= fe_data[gi];
			f2 <= f1;
		end
		always @(posedge clk)
			q <= phase_sel[gi] ? f2 : r2;

		assign bit_in = q & ~chan_mask[gi] & link_ok[LNK];

		always @(posedge clk)
		begin
			if (rst)
			begin
				step  <= 2'h0;
				sb    <= 1'b0;
				timer <= 4'h0;
				hv    <= 4'h0;
			end
			else
			begin
				if (lclk_edge[BRD])
				begin
					case (step)
						2'h0:
							step <= bit_in ? 2'h1 : 2'h0;
						2'h1:
						begin
							sb   <= bit_in;
							step <= 2'h2;
						end
						default:
							step <= 2'h0;
					endcase
				end
				if (lclk_edge[BRD] && step == 2'h2)
				begin
					hv    <= `CSF_ONE4 << {sb, bit_in};
					timer <= stretch_len;
				end
				else if (timer > `CSF_ONE4)
					timer <= timer - `CSF_ONE4;
				else
				begin
					timer <= 4'h0;
					hv    <= 4'h0;
				end
			end
		end

		assign raw[gi] = q;
		assign hs[HSI +: `CSF_HS_PER_DS] = hv;
		assign ds[DSI] = |hv;
	end
endgenerate

// ****************************************************************
// Pre-trigger, pattern search and segment selection
// ****************************************************************

reg  [2:0]                  state;
reg  [3:0]                  dly;
reg  [4:0]                  hold_crossing;
reg  [`CSF_WORD_W-1:0]      w1;
reg  [`CSF_WORD_W-1:0]      w2;
reg                         two;
reg                         pt_any;
reg                         sel_one;
reg                         sel_two;
reg  [`CSF_WORD_W-1:0]      sel_w1;
reg  [`CSF_WORD_W-1:0]      sel_w2;
reg  [`CSF_NHS-1:0]         vv;
reg  [2:0]                  lay;
reg  [7:0]                  pn;
reg  [7:0]                  bpn;
reg                         bb;
reg  [`CSF_NCAND*8-1:0]     c_pn;
reg  [`CSF_NCAND*8-1:0]     c_pos;
reg  [`CSF_NCAND-1:0]       c_bend;
wire [`CSF_NHS-1:0]         ds_ext;
integer                     t, k, s, l, g, w, i, i1, i2;

assign ds_ext = {{(`CSF_NHS-`CSF_NDS){1'b0}}, ds};

// Full-chamber maps mean windows reach across board edges, so a
// boundary track is seen by keys in both neighbouring groups. Cost: one wide block.
always @*
begin
	pt_any = 1'b0;
	c_pn   = {(`CSF_NCAND*8){1'b0}};
	c_pos  = {(`CSF_NCAND*8){1'b0}};
	c_bend = {`CSF_NCAND{1'b0}};
	vv     = {`CSF_NHS{1'b0}};
	lay    = 3'h0;
	pn     = 8'h00;
	bpn    = 8'h00;
	bb     = 1'b0;
	for (k = 0; k < `CSF_DSW; k = k + 1)
	begin
		lay = 3'h0;
		for (l = 0; l < `CSF_NLAY; l = l + 1)
			lay = lay + {2'h0, win3(ds_ext, l, k, `CSF_DSW)};
		if (lay >= pretrig_n)
			pt_any = 1'b1;
	end
	for (t = 0; t < 2; t = t + 1)
	begin
		w  = (t == 0) ? `CSF_HSW : `CSF_DSW;
		vv = (t == 0) ? hs : ds_ext;
		for (k = 0; k < w; k = k + 1)
		begin
			bpn = 8'h00;
			bb  = 1'b0;
			for (s = 0; s < `CSF_NPAT; s = s + 1)
			begin
				lay = 3'h0;
				for (l = 0; l < `CSF_NLAY; l = l + 1)
					lay = lay + {2'h0, win3(vv, l,
						k + ((s == 1) ? `CSF_KEY_LAY - l : (s == 2) ? l - `CSF_KEY_LAY : 0), w)};
				pn = mkpn(t == 0, lay, s);
				if (lay >= pattern_m && pn > bpn)
				begin
					bpn = pn;
					bb  = (s == 2);
				end
			end
			g = (t == 0) ? k / `CSF_GRP_HS : `CSF_NGRP + k / `CSF_GRP_DS;
			if (bpn > c_pn[g * 8 +: 8])
			begin
				c_pn[g * 8 +: 8]  = bpn;
				c_pos[g * 8 +: 8] = k[7:0];
				c_bend[g]         = bb;
			end
		end
	end
	i1 = 0;
	for (i = 1; i < `CSF_NCAND; i = i + 1)
		if (c_pn[i * 8 +: 8] > c_pn[i1 * 8 +: 8])
			i1 = i;
	i2 = (i1 == 0) ? 1 : 0;
	for (i = 1; i < `CSF_NCAND; i = i + 1)
		if (i != i1 && c_pn[i * 8 +: 8] > c_pn[i2 * 8 +: 8])
			i2 = i;
	sel_one = (c_pn[i1 * 8 +: 8] != 8'h00);
	sel_two = (c_pn[i2 * 8 +: 8] != 8'h00);
	sel_w1 = mkword(c_pn[i1 * 8 +: 8], c_bend[i1], i1 < `CSF_NGRP, c_pos[i1 * 8 +: 8],
		hold_crossing);
	sel_w2 = mkword(c_pn[i2 * 8 +: 8], c_bend[i2], i2 < `CSF_NGRP, c_pos[i2 * 8 +: 8],
		hold_crossing);
end

// ****************************************************************
// Trigger sequence and output queue
// ****************************************************************

wire                   fifo_in_valid;
wire                   fifo_in_ready;
wire [`CSF_WORD_W-1:0] fifo_in_data;
wire                   fifo_out_valid;
wire                   fifo_out_ready;
wire [`CSF_WORD_W-1:0] fifo_out_data;

assign fifo_in_valid  = (state == ST_PUSH1) || (state == ST_PUSH2);
assign fifo_in_data   = (state == ST_PUSH2) ? w2 : w1;
assign fifo_out_ready = ~seg_valid | seg_ready;

always @(posedge clk)
begin
	if (rst)
	begin
		state         <= ST_IDLE;
		dly           <= 4'h0;
		hold_crossing <= 5'h00;
		w1            <= {`CSF_WORD_W{1'b0}};
		w2            <= {`CSF_WORD_W{1'b0}};
		two           <= 1'b0;
		pretrig       <= 1'b0;
	end
	else
	begin
		pretrig <= (state == ST_IDLE) & pt_any;
		case (state)
			ST_IDLE:
				if (pt_any)
				begin
					hold_crossing <= crossing;
					dly           <= pretrig_delay;
					state         <= ST_DELAY;
				end
			ST_DELAY:
				if (dly > `CSF_ONE4)
					dly <= dly - `CSF_ONE4;
				else
					state <= ST_EVAL;
			ST_EVAL:
			begin
				w1    <= sel_w1;
				w2    <= sel_w2;
				two   <= sel_two;
				state <= sel_one ? ST_PUSH1 : ST_IDLE;
			end
			// A full queue stalls the search; no segment is dropped.
			ST_PUSH1:
				if (fifo_in_ready)
					state <= two ? ST_PUSH2 : ST_IDLE;
			ST_PUSH2:
				if (fifo_in_ready)
					state <= ST_IDLE;
			default:
				state <= ST_IDLE;
		endcase
	end
end

csf_fifo #(
	.WIDTH  (`CSF_WORD_W),
	.DEPTH  (`CSF_FIFO_DEPTH),
	.ADDR_W (`CSF_FIFO_AW)
) csf_fifo_inst (
	.clk       (clk),
	.rst       (rst),
	.in_valid  (fifo_in_valid),
	.in_ready  (fifo_in_ready),
	.in_data   (fifo_in_data),
	.out_valid (fifo_out_valid),
	.out_ready (fifo_out_ready),
	.out_data  (fifo_out_data)
);

always @(posedge clk)
begin
	if (rst)
	begin
		seg_valid <= 1'b0;
		seg_word  <= {`CSF_WORD_W{1'b0}};
	end
	else if (fifo_out_ready)
	begin
		seg_valid <= fifo_out_valid;
		seg_word  <= fifo_out_valid ? fifo_out_data : {`CSF_WORD_W{1'b0}};
	end
end

// ****************************************************************
// Diagnostic pipeline and serial readout
// ****************************************************************

reg [`CSF_NDS-1:0] pipe [0:`CSF_PIPE_DEPTH-1];
reg [`CSF_NDS-1:0] shreg;
reg [7:0]          rd_cnt;
reg                frozen;
reg                reading;
reg [4:0]          frz_crossing;
reg                acc_s1;
reg                acc_s2;
reg                acc_s3;
reg [4:0]          accx_s1;
reg [4:0]          accx_s2;
integer            p;

always @(posedge clk)
begin
	if (!frozen)
	begin
		pipe[0] <= raw;
		for (p = 1; p < `CSF_PIPE_DEPTH; p = p + 1)
			pipe[p] <= pipe[p - 1];
	end
end

always @(posedge clk)
begin
	acc_s1  <= level_one_accept;
	acc_s2  <= acc_s1;
	acc_s3  <= acc_s2;
	accx_s1 <= level_one_accept_crossing;
	accx_s2 <= accx_s1;
	if (rst)
	begin
		frozen       <= 1'b0;
		reading      <= 1'b0;
		rd_cnt       <= 8'h00;
		shreg        <= {`CSF_NDS{1'b0}};
		frz_crossing <= 5'h00;
		diag_bit     <= 1'b0;
		diag_valid   <= 1'b0;
	end
	else
	begin
		diag_valid <= reading;
		diag_bit   <= reading & shreg[0];
		if (reading)
		begin
			shreg  <= shreg >> 1;
			rd_cnt <= rd_cnt + 8'h01;
			if (rd_cnt == `CSF_RD_LAST)
			begin
				reading <= 1'b0;
				frozen  <= 1'b0;
			end
		end
		// Accept of the frozen crossing.
		// Accept must be seen on two edges so that the crossing word has settled.
		else if (frozen && acc_s2 && acc_s3 && accx_s2 == frz_crossing)
		begin
			reading <= 1'b1;
			rd_cnt  <= 8'h00;
			shreg   <= pipe[`CSF_PIPE_DEPTH-1];
		end
		if (state == ST_EVAL && sel_one && !frozen)
		begin
			frozen       <= 1'b1;
			frz_crossing <= hold_crossing;
		end
	end
end

endmodule
`default_nettype wire

/* bench/csf_fe_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.vh"

// ****
// Front-end board model.
// ****
module csf_fe_model (
	output logic [`CSF_NDS-1:0]        fe_data,       // Triad lines.
	output logic [`CSF_NBRD-1:0]       fe_clk,        // Link clock per board.
	output logic [`CSF_NLINK-1:0]      fe_link_id,    // Link identifier bits.
	output logic [`CSF_NLINK-1:0]      fe_link_alive, // Board powered bits.
	input  wire logic [`CSF_NLINK-1:0] alive_en       // Power switch per link.
);
	assign fe_link_id = 10'h2aa;
	assign fe_link_alive = alive_en;

	// The link clock stands still low between frames, so no stray step is decoded.
	initial
	begin
		fe_data = '0;
		fe_clk = '0;
	end

	task automatic send(input logic [`CSF_NDS-1:0] hit, strip, half);
		logic [`CSF_NDS-1:0] b [3];
		b[0] = hit;
		b[1] = hit & strip;
		b[2] = hit & half;
		// Frames start off the board-clock edges, so pin changes never race the sampling flops.
		#10;
		for (int k = 0; k < 3; k++)
		begin
			fe_data = b[k];
			#160;
			fe_clk = '1;
			#160;
			fe_clk = '0;
		end
		fe_data = '0;
	endtask
endmodule
`default_nettype wire

/* bench/csf_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "csf_consts.vh"

// ****
// Output checks.
// ****
module csf_top_sva (
	input wire logic                    clk,           // Board clock.
	input wire logic                    rst,           // Synchronous reset.
	input wire logic [`CSF_NLINK-1:0]   fe_link_alive, // Link-alive bits.
	input wire logic [2:0]              pattern_m,     // Pattern layer threshold.
	input wire logic                    seg_ready,     // Word taken.
	input wire logic [`CSF_WORD_W-1:0]  seg_word,      // Segment word.
	input wire logic                    seg_valid,     // Word presented.
	input wire logic                    pretrig,       // Pre-trigger pulse.
	input wire logic [`CSF_NLINK-1:0]   link_ok,       // Link status.
	input wire logic                    diag_valid     // Diagnostic bit valid.
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	word_flag_a: assert property (seg_valid |-> seg_word[23])
		else $error("valid word lacks its flag");
	idle_zero_a: assert property (!seg_valid |-> seg_word == 24'h0)
		else $error("word not zero while idle");
	word_hold_a: assert property (seg_valid && !seg_ready |=> seg_valid && $stable(seg_word))
		else $error("word dropped before taken");
	hs_range_a: assert property (seg_valid && seg_word[13] |-> seg_word[12:5] <= 8'h9f)
		else $error("half-strip position out of range");
	ds_range_a: assert property (seg_valid && !seg_word[13] |-> seg_word[12:5] <= 8'h27)
		else $error("di-strip position out of range");
	kind_bit_a: assert property (seg_valid |-> seg_word[22] == seg_word[13])
		else $error("kind bit disagrees with pattern");
	layer_min_a: assert property (seg_valid |-> seg_word[21:19] >= pattern_m)
		else $error("segment below layer threshold");
	bend_dir_a: assert property (seg_valid |-> seg_word[14] == (seg_word[16:15] == 2'h2))
		else $error("bend bit disagrees with pattern");
	pretrig_gap_a: assert property (pretrig |=> !pretrig [*2])
		else $error("pre-trigger during delay");
	link_dead_a: assert property (!fe_link_alive[0] [*4] |-> !link_ok[0])
		else $error("dead link reported alive");

	cover property (seg_valid && !seg_ready);
	cover property ($rose(diag_valid));
	cover property (pretrig);
endmodule

bind csf_top csf_top_sva csf_top_sva_inst (.clk(clk), .rst(rst), .fe_link_alive(fe_link_alive),
	.pattern_m(pattern_m), .seg_ready(seg_ready), .seg_word(seg_word), .seg_valid(seg_valid),
	.pretrig(pretrig), .link_ok(link_ok), .diag_valid(diag_valid));
`default_nettype wire

/* bench/csf_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module csf_top_bench;
	logic         clk, rst, accept, seg_ready;
	logic [4:0]   acc_cr, pt_cr;
	logic [239:0] phase_sel, chan_mask, tk;
	logic [2:0]   pt_n;
	logic [9:0]   alive_en;
	logic [15:0]  cyc = 16'h0;
	logic [23:0]  w;
	wire  [239:0] fe_data;
	wire  [4:0]   fe_clk;
	wire  [9:0]   fe_link_id, fe_link_alive, link_ok;
	wire  [23:0]  seg_word;
	wire          seg_valid, pretrig, diag_bit, diag_valid;
	int           num_errors = 0, compares = 0, pt_cnt = 0, sv_cnt = 0, dv_cnt = 0, db_cnt = 0;

	csf_fe_model csf_fe_model_inst (.fe_data(fe_data), .fe_clk(fe_clk), .fe_link_id(fe_link_id),
		.fe_link_alive(fe_link_alive), .alive_en(alive_en));
	csf_top csf_top_inst (.clk(clk), .rst(rst), .fe_data(fe_data), .fe_clk(fe_clk),
		.fe_link_id(fe_link_id), .fe_link_alive(fe_link_alive), .phase_sel(phase_sel),
		.chan_mask(chan_mask), .stretch_len(4'h5), .pretrig_n(pt_n), .pattern_m(3'h4),
		.pretrig_delay(4'h1), .level_one_accept(accept), .level_one_accept_crossing(acc_cr),
		.seg_ready(seg_ready), .seg_word(seg_word), .seg_valid(seg_valid), .pretrig(pretrig),
		.link_ok(link_ok), .diag_bit(diag_bit), .diag_valid(diag_valid));

	// ****
	// Clock, crossing mirror and monitors.
	// ****
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
		cyc <= rst ? 16'h0 : cyc + 16'h1;

	// The crossing is latched at the edge that raises the pulse, one count behind ours.
	always @(negedge clk)
	begin
		if (pretrig === 1'b1)
		begin
			pt_cr = cyc[4:0] - 5'h1;
			pt_cnt++;
		end
		if (seg_valid === 1'b1)
			sv_cnt++;
		if (diag_valid === 1'b1)
			dv_cnt++;
		if (diag_valid === 1'b1 && diag_bit === 1'b1)
			db_cnt++;
	end

	// ****
	// Tasks.
	// ****
	task automatic chk_word(input logic [23:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_num(input logic [15:0] got, exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic get_word(output logic [23:0] got);
		int n;
		n = 0;
		@(negedge clk);
		while (seg_valid !== 1'b1 && n < 200)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 200)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, seg_valid, 1'b1);
		end
		got = seg_word;
	endtask

	task automatic take();
		@(posedge clk);
		seg_ready <= 1'b1;
		@(posedge clk);
		seg_ready <= 1'b0;
	endtask

	task automatic accept_at(input logic [4:0] cr);
		@(posedge clk);
		acc_cr <= cr;
		accept <= 1'b1;
		repeat (4) @(posedge clk);
		accept <= 1'b0;
	endtask

	function automatic logic [239:0] track(input int brd, line, input logic [5:0] lays);
		logic [239:0] v;
		v = '0;
		for (int l = 0; l < 6; l++)
			if (lays[l])
				v[brd * 48 + l * 8 + line] = 1'b1;
		return v;
	endfunction

	task automatic give_verdict();
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (6000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	// ****
	// Tests.
	// ****
	initial
	begin
		rst = 1'b1;
		accept = 1'b0;
		acc_cr = 5'h0;
		seg_ready = 1'b0;
		phase_sel = '0;
		chan_mask = '0;
		alive_en = 10'h3ff;
		pt_n = 3'h2;
		tk = track(1, 2, 6'h3f);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(negedge clk);
		chk_num({6'h0, link_ok}, 16'h03ff);
		@(posedge clk);
		alive_en <= 10'h3fe;
		repeat (6) @(negedge clk);
		chk_num({6'h0, link_ok}, 16'h03fe);
		@(posedge clk);
		alive_en <= 10'h3ff;
		repeat (6) @(posedge clk);
		$display("test links done");

		// Six-layer straight track on half-strip 43; the lowest matching key wins.
		// The third triad bit is set on the track lines, so the frozen stage holds six ones.
		csf_fe_model_inst.send(tk, tk, tk);
		get_word(w);
		chk_word(w, {1'b1, 8'he8, 2'h1, 8'h2a, pt_cr});
		repeat (4) @(negedge clk);
		chk_word(seg_word, {1'b1, 8'he8, 2'h1, 8'h2a, pt_cr});
		take();
		get_word(w);
		chk_word(w, {1'b1, 8'h68, 2'h0, 8'h09, pt_cr});
		take();
		repeat (4) @(negedge clk);
		chk_num({15'h0, seg_valid}, 16'h0);
		$display("test track done");

		dv_cnt = 0;
		db_cnt = 0;
		accept_at(pt_cr + 5'h1);
		repeat (20) @(negedge clk);
		chk_num(dv_cnt[15:0], 16'h0);
		accept_at(pt_cr);
		repeat (300) @(negedge clk);
		chk_num(dv_cnt[15:0], 16'h00f0);
		chk_num(db_cnt[15:0], 16'h0006);
		$display("test diagnostics done");

		@(posedge clk);
		chan_mask <= track(1, 2, 6'h07);
		phase_sel <= '1;
		pt_cnt = 0;
		sv_cnt = 0;
		csf_fe_model_inst.send(tk, tk, '0);
		repeat (40) @(negedge clk);
		chk_num({15'h0, pt_cnt != 0}, 16'h1);
		chk_num(sv_cnt[15:0], 16'h0);
		// Three live layers no longer reach a raised pre-trigger threshold.
		@(posedge clk);
		pt_n <= 3'h4;
		pt_cnt = 0;
		csf_fe_model_inst.send(tk, tk, '0);
		repeat (40) @(negedge clk);
		chk_num(pt_cnt[15:0], 16'h0);
		$display("test mask done");
		give_verdict();
	end
endmodule
`default_nettype wire
